//--- store_seq_pkg.sv
// shared constants for the persistent store sequencer
package store_seq_pkg;
  // register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] CONTROL_OFF  = 8'h00;
  localparam logic [7:0] KEY_OFF      = 8'h04;
  localparam logic [7:0] LOC_LOW_OFF  = 8'h08;
  localparam logic [7:0] LOC_HIGH_OFF = 8'h0C;
  localparam logic [7:0] PAYLOAD_OFF  = 8'h10;
  localparam logic [7:0] STATUS_OFF   = 8'h14;
  localparam logic [7:0] PROTECT_OFF  = 8'h18;
  // store_control_reg fields
  localparam int GO_BIT     = 0;
  localparam int PERMIT_BIT = 1;
  localparam int ERASE_BIT  = 2;
  localparam int SPACE_BIT  = 3;
  localparam int FLAG_BIT   = 4;
  localparam int MASK_BIT   = 5;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] PROTECT_RESET = 8'h00;
  // unlock keys
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // location map
  localparam logic [14:0] EEPROM_BASE   = 15'h7000;
  localparam logic [14:0] EEPROM_LAST   = 15'h70FF;
  localparam logic [14:0] USERID_LAST   = 15'h0003;
  localparam logic [14:0] CONFIG_FIRST  = 15'h0007;
  localparam logic [14:0] CONFIG_LAST   = 15'h000B;
  localparam int ROW_WORDS  = 32;
  localparam int ROW_SHIFT  = 5;
  localparam logic [13:0] LATCH_BLANK = 14'h3FFF;
  localparam logic [15:0] LATCH_BLANK_WORD = 16'h7FFF;
  // timing
  localparam int CLK_MHZ         = 25;
  localparam int EE_WRITE_US     = 4;
  localparam int ROW_ERASE_US    = 2;
  localparam int EE_WRITE_CYC    = EE_WRITE_US * CLK_MHZ;
  localparam int ROW_ERASE_CYC   = ROW_ERASE_US * CLK_MHZ;
  localparam int TIMER_W         = 12;
  // axi answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_ONE  = 2'b01,
    KEY_TWO  = 2'b10
  } key_state_t;
  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_EE    = 2'b01,
    OP_ERASE = 2'b10
  } op_state_t;
endpackage

//--- store_op_timer.sv
// down counter that times one write or erase operation
`timescale 1ns/1ns
`default_nettype none
module store_op_timer
  import store_seq_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               load,
  input  wire logic [TIMER_W-1:0] count,
  output logic                    done
);
  logic [TIMER_W-1:0] remain;
  logic [TIMER_W-1:0] next_remain;
  logic               next_done;

  always_comb begin
    next_remain = remain;
    next_done   = 1'b0;
    if (load) begin
      next_remain = count;
    end else if (remain != '0) begin
      next_remain = remain - 1'b1;
      next_done   = (remain == 12'h001);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      remain <= '0;
      done   <= 1'b0;
    end else begin
      remain <= next_remain;
      done   <= next_done;
    end
  end
endmodule
`default_nettype wire

//--- persistent_store_sequencer.sv
// keyed write/erase sequencer for data eeprom and code flash rows
// What this block does
// - go starts only after keys 55h then AAh
// - any bus write with right effect counts
// - eeprom byte sits at index plus 7000h
// - eeprom write erases its byte itself
// - cpu keeps running during eeprom write
// - done: go clears, flag sets, permit kept
// - clearing go during eeprom write ignored
// - flash erases whole rows, never auto-erases
// - protected row erase clears go, no erase
// - row erase stalls cpu, then sets flag
// - row erase keeps permit; latches reset after it
// - space select picks flash or config space
// - writes to protected targets are blocked
// - an erase row is 32 words
// - latches return to 7FFFh after operations
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module persistent_store_sequencer
  import store_seq_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             cpu_stall,
  output logic             completion_irq,
  output logic             mem_write,
  output logic             mem_row_erase,
  output logic             mem_space,
  output logic [14:0]      mem_location,
  output logic [7:0]       mem_payload,
  output logic             latch_reset
);
  logic [7:0]  store_control_reg, next_control;
  logic [7:0]  payload_reg, next_payload;
  logic [7:0]  target_location_low, next_loc_low;
  logic [6:0]  target_location_high, next_loc_high;
  logic [7:0]  protect_reg, next_protect;
  key_state_t  key_state, next_key_state;
  op_state_t   op_state, next_op_state;
  logic        aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        next_awready, next_wready, next_bvalid;
  logic        next_arready, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic        next_stall, next_irq, next_mem_write, next_mem_erase;
  logic        next_latch_reset;
  logic        wr_fire, wr_ok, timer_load, timer_done;
  logic [TIMER_W-1:0] timer_count;
  logic [14:0] location;
  logic        is_eeprom, is_writable, is_protected, go_keyed;

  assign location = {target_location_high, target_location_low};
  assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
  assign wr_ok    = wr_fire && w_strb[0];

  // map: eeprom window, user id, config words
  always_comb begin
    is_eeprom   = store_control_reg[SPACE_BIT] &&
                  location >= EEPROM_BASE && location <= EEPROM_LAST;
    is_writable = 1'b1;
    if (store_control_reg[SPACE_BIT]) begin
      is_writable = is_eeprom || location <= USERID_LAST ||
                    (location >= CONFIG_FIRST && location <= CONFIG_LAST);
    end
    // protect_reg bit n guards flash block n of the top address bits;
    // bit 7 guards the whole config space
    if (store_control_reg[SPACE_BIT]) begin
      is_protected = protect_reg[7] || !is_writable;
    end else begin
      is_protected = protect_reg[location[14:12]];
    end
  end

  // a go write is keyed only if the previous write with byte 0 strobe was AAh after 55h
  assign go_keyed = (key_state == KEY_TWO);

  always_comb begin
    next_aw_held  = aw_held;
    next_aw_addr  = aw_addr;
    next_w_held   = w_held;
    next_w_data   = w_data;
    next_w_strb   = w_strb;
    next_awready  = 1'b0;
    next_wready   = 1'b0;
    next_bvalid   = s_axi_bvalid && !s_axi_bready;
    next_bresp    = s_axi_bresp;
    next_arready  = 1'b0;
    next_rvalid   = s_axi_rvalid && !s_axi_rready;
    next_rresp    = s_axi_rresp;
    next_rdata    = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (!aw_held && !s_axi_awready && s_axi_awvalid) begin
      next_awready = 1'b1;
    end
    if (!w_held && !s_axi_wready && s_axi_wvalid) begin
      next_wready = 1'b1;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (aw_addr > PROTECT_OFF) ? RESP_SLVERR : RESP_OKAY;
    end
    if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
      next_arready = 1'b1;
      next_rvalid  = 1'b1;
      next_rresp   = RESP_OKAY;
      unique case (s_axi_araddr)
        CONTROL_OFF:  next_rdata = {24'h000000, store_control_reg};
        KEY_OFF:      next_rdata = 32'h00000000;
        LOC_LOW_OFF:  next_rdata = {24'h000000, target_location_low};
        LOC_HIGH_OFF: next_rdata = {25'h0000000, target_location_high};
        PAYLOAD_OFF:  next_rdata = {24'h000000, payload_reg};
        STATUS_OFF:   next_rdata = {30'h00000000, op_state};
        PROTECT_OFF:  next_rdata = {24'h000000, protect_reg};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_comb begin
    next_control    = store_control_reg;
    next_payload    = payload_reg;
    next_loc_low    = target_location_low;
    next_loc_high   = target_location_high;
    next_protect    = protect_reg;
    next_key_state  = key_state;
    next_op_state   = op_state;
    next_mem_write  = 1'b0;
    next_mem_erase  = 1'b0;
    next_latch_reset = 1'b0;
    next_stall      = cpu_stall;
    timer_load      = 1'b0;
    timer_count     = '0;
    // any write with byte 0 strobe advances or breaks the key chain
    if (wr_ok) begin
      next_key_state = KEY_IDLE;
      if (aw_addr == KEY_OFF && w_data[7:0] == KEY_FIRST) begin
        next_key_state = KEY_ONE;
      end else if (aw_addr == KEY_OFF && w_data[7:0] == KEY_SECOND &&
                   key_state == KEY_ONE) begin
        next_key_state = KEY_TWO;
      end
      unique case (aw_addr)
        CONTROL_OFF: begin
          next_control[PERMIT_BIT] = w_data[PERMIT_BIT];
          next_control[ERASE_BIT]  = w_data[ERASE_BIT];
          next_control[SPACE_BIT]  = w_data[SPACE_BIT];
          next_control[MASK_BIT]   = w_data[MASK_BIT];
          // flag is write-zero-to-clear
          if (!w_data[FLAG_BIT]) begin
            next_control[FLAG_BIT] = 1'b0;
          end
          // go cannot be cleared by software while busy
          if (op_state == OP_IDLE) begin
            next_control[GO_BIT] = 1'b0;
            if (w_data[GO_BIT] && go_keyed &&
                store_control_reg[PERMIT_BIT]) begin
              next_control[GO_BIT] = 1'b1;
            end
          end
        end
        LOC_LOW_OFF:  next_loc_low  = w_data[7:0];
        LOC_HIGH_OFF: next_loc_high = w_data[6:0];
        PAYLOAD_OFF:  next_payload  = w_data[7:0];
        PROTECT_OFF:  next_protect  = w_data[7:0];
        default: begin
        end
      endcase
    end
    unique case (op_state)
      OP_IDLE: begin
        if (store_control_reg[GO_BIT]) begin
          if (is_protected) begin
            next_control[GO_BIT] = 1'b0;
          end else if (!store_control_reg[ERASE_BIT] && is_eeprom) begin
            // byte write carries its own erase; cpu not stalled
            next_mem_write = 1'b1;
            timer_load     = 1'b1;
            timer_count    = TIMER_W'(EE_WRITE_CYC);
            next_op_state  = OP_EE;
          end else if (store_control_reg[ERASE_BIT]) begin
            // whole row only; the location's low bits are ignored
            next_mem_erase = 1'b1;
            next_stall     = 1'b1;
            timer_load     = 1'b1;
            timer_count    = TIMER_W'(ROW_ERASE_CYC);
            next_op_state  = OP_ERASE;
          end else begin
            // latch programming lives outside this block
            next_control[GO_BIT] = 1'b0;
          end
        end
      end
      OP_EE, OP_ERASE: begin
        if (timer_done) begin
          // permit bit untouched; set wins over a same-cycle clear
          next_control[GO_BIT]   = 1'b0;
          next_control[FLAG_BIT] = 1'b1;
          next_latch_reset       = 1'b1;
          next_stall             = 1'b0;
          next_op_state          = OP_IDLE;
        end
      end
      default: next_op_state = OP_IDLE;
    endcase
    next_irq = next_control[FLAG_BIT] && next_control[MASK_BIT];
  end

  store_op_timer op_timer (
    .clk   (clk),
    .rst_b (rst_b),
    .load  (timer_load),
    .count (timer_count),
    .done  (timer_done)
  );

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      store_control_reg    <= CONTROL_RESET;
      payload_reg          <= 8'h00;
      target_location_low  <= 8'h00;
      target_location_high <= 7'h00;
      protect_reg          <= PROTECT_RESET;
      key_state            <= KEY_IDLE;
      op_state             <= OP_IDLE;
      aw_held              <= 1'b0;
      aw_addr              <= 8'h00;
      w_held               <= 1'b0;
      w_data               <= 32'h00000000;
      w_strb               <= 4'h0;
      s_axi_awready        <= 1'b0;
      s_axi_wready         <= 1'b0;
      s_axi_bvalid         <= 1'b0;
      s_axi_bresp          <= RESP_OKAY;
      s_axi_arready        <= 1'b0;
      s_axi_rvalid         <= 1'b0;
      s_axi_rresp          <= RESP_OKAY;
      s_axi_rdata          <= 32'h00000000;
      cpu_stall            <= 1'b0;
      completion_irq       <= 1'b0;
      mem_write            <= 1'b0;
      mem_row_erase        <= 1'b0;
      mem_space            <= 1'b0;
      mem_location         <= 15'h0000;
      mem_payload          <= 8'h00;
      latch_reset          <= 1'b0;
    end else begin
      store_control_reg    <= next_control;
      payload_reg          <= next_payload;
      target_location_low  <= next_loc_low;
      target_location_high <= next_loc_high;
      protect_reg          <= next_protect;
      key_state            <= next_key_state;
      op_state             <= next_op_state;
      aw_held              <= next_aw_held;
      aw_addr              <= next_aw_addr;
      w_held               <= next_w_held;
      w_data               <= next_w_data;
      w_strb               <= next_w_strb;
      s_axi_awready        <= next_awready;
      s_axi_wready         <= next_wready;
      s_axi_bvalid         <= next_bvalid;
      s_axi_bresp          <= next_bresp;
      s_axi_arready        <= next_arready;
      s_axi_rvalid         <= next_rvalid;
      s_axi_rresp          <= next_rresp;
      s_axi_rdata          <= next_rdata;
      cpu_stall            <= next_stall;
      completion_irq       <= next_irq;
      mem_write            <= next_mem_write;
      mem_row_erase        <= next_mem_erase;
      mem_space            <= store_control_reg[SPACE_BIT];
      mem_location         <= next_mem_erase ?
                              {location[14:ROW_SHIFT], 5'h00} : location;
      mem_payload          <= payload_reg;
      latch_reset          <= next_latch_reset;
    end
  end

  // assertions
  default clocking assert_clk @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence keyed_go_s;
    key_state == KEY_TWO ##0 wr_ok ##0 aw_addr == CONTROL_OFF;
  endsequence

  keyed_go_a: assert property (
    keyed_go_s ##0 (w_data[GO_BIT] && store_control_reg[PERMIT_BIT]
    && op_state == OP_IDLE && !store_control_reg[GO_BIT])
    |=> store_control_reg[GO_BIT])
    else $error("keyed go was lost");
  go_needs_key_a: assert property (
    $rose(store_control_reg[GO_BIT]) |-> $past(go_keyed))
    else $error("go set without key sequence");
  unkeyed_go_a: assert property (
    (wr_ok && aw_addr == CONTROL_OFF && !go_keyed && op_state == OP_IDLE)
    |=> !store_control_reg[GO_BIT])
    else $error("unkeyed go took effect");
  ee_no_stall_a: assert property (
    op_state == OP_EE |-> !cpu_stall)
    else $error("cpu stalled during eeprom write");
  erase_stall_a: assert property (
    $rose(mem_row_erase) |-> cpu_stall [*8])
    else $error("cpu not stalled during erase");
  done_flag_a: assert property (
    (op_state != OP_IDLE && timer_done) |=>
    store_control_reg[FLAG_BIT] && !store_control_reg[GO_BIT]
    && latch_reset && $stable(store_control_reg[PERMIT_BIT]))
    else $error("completion not reported");
  go_held_busy_a: assert property (
    (op_state == OP_EE && !timer_done) |=> store_control_reg[GO_BIT])
    else $error("go dropped during write");
  protect_abort_a: assert property (
    (op_state == OP_IDLE && store_control_reg[GO_BIT] && is_protected)
    |=> !store_control_reg[GO_BIT] && !mem_row_erase && !mem_write)
    else $error("protected target was written");
  ee_duration_a: assert property (
    $rose(mem_write) |-> ##[100:103] store_control_reg[FLAG_BIT])
    else $error("eeprom write time wrong");
  row_align_a: assert property (
    mem_row_erase |-> mem_location[4:0] == 5'h00)
    else $error("erase not row aligned");
  irq_gate_a: assert property (
    completion_irq == (store_control_reg[FLAG_BIT]
                       && store_control_reg[MASK_BIT]))
    else $error("irq disagrees with flag and mask");
endmodule
`default_nettype wire

//--- cpu_bus_model.sv
// cpu side bus master that issues the register traffic
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_model
  import store_seq_pkg::*;
(
  input  wire logic        clk,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  logic        timed_out;
  logic [1:0]  resp;
  logic [31:0] rdata;
  initial begin
    timed_out = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
  end
  // one transfer; data is scrambled once taken so a late sample shows
  task automatic xfer(input logic is_rd, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
    logic aw_d;
    logic w_d;
    logic got;
    int   n;
    aw_d = is_rd;
    w_d = is_rd;
    got = 1'b0;
    n = 0;
    if (is_rd) begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end else begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end
    while (!got && n < 300) begin
      @(posedge clk);
      n++;
      if (!aw_d && s_axi_awready === 1'b1) begin
        aw_d = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_d && s_axi_wready === 1'b1) begin
        w_d = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (is_rd && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      got = is_rd ? (s_axi_rvalid === 1'b1) : (s_axi_bvalid === 1'b1);
      resp = is_rd ? s_axi_rresp : s_axi_bresp;
      rdata = s_axi_rdata;
    end
    timed_out = timed_out | !got;
    s_axi_rready <= 1'b0;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  // no interrupt can land between the key steps here
  task automatic unlock(input logic [7:0] ctrl);
    xfer(1'b0, KEY_OFF, {24'h0, KEY_FIRST}, 4'hF);
    xfer(1'b0, KEY_OFF, {24'h0, KEY_SECOND}, 4'hF);
    xfer(1'b0, CONTROL_OFF, {24'h0, ctrl | 8'h01}, 4'hF);
  endtask
  task automatic poll_go();
    int n;
    n = 0;
    xfer(1'b1, CONTROL_OFF, 32'h0, 4'h0);
    while (rdata[GO_BIT] !== 1'b0 && n < 400) begin
      xfer(1'b1, CONTROL_OFF, 32'h0, 4'h0);
      n++;
    end
    timed_out = timed_out | (n >= 400);
  endtask
endmodule
`default_nettype wire

//--- tb.sv
// self-checking bench for the persistent store sequencer
`timescale 1ns/1ns
`default_nettype none
module tb
  import store_seq_pkg::*;
;
  logic        clk, rst_b, cpu_stall, completion_irq, mem_write;
  logic        mem_row_erase, mem_space, latch_reset;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, mem_payload;
  logic [14:0] mem_location, op_loc;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          failures, n_tests, n_wr, n_er, n_lr, n_stall;
  persistent_store_sequencer i_persistent_store_sequencer (
    .clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cpu_stall, .completion_irq,
    .mem_write, .mem_row_erase, .mem_space, .mem_location,
    .mem_payload, .latch_reset
  );
  cpu_bus_model i_cpu_bus_model (
    .clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // memory side activity is counted so each scenario can judge it
  always @(posedge clk) begin
    n_wr <= n_wr + int'(mem_write === 1'b1);
    n_er <= n_er + int'(mem_row_erase === 1'b1);
    n_lr <= n_lr + int'(latch_reset === 1'b1);
    n_stall <= n_stall + int'(cpu_stall === 1'b1);
    if (mem_write === 1'b1 || mem_row_erase === 1'b1) op_loc <= mem_location;
  end
  task automatic final_report();
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic hang_check();
    if (i_cpu_bus_model.timed_out === 1'b1) begin
      failures++;
      final_report();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_cpu_bus_model.xfer(1'b0, a, d, 4'hF);
    hang_check();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    i_cpu_bus_model.xfer(1'b1, a, 32'h0, 4'h0);
    hang_check();
    check(i_cpu_bus_model.rdata, exp);
  endtask
  task automatic launch(input logic [7:0] prot, input logic [14:0] loc,
                        input logic [7:0] ctrl);
    wr(PROTECT_OFF, {24'h0, prot});
    wr(LOC_LOW_OFF, {24'h0, loc[7:0]});
    wr(LOC_HIGH_OFF, {25'h0, loc[14:8]});
    wr(CONTROL_OFF, {24'h0, ctrl});
    i_cpu_bus_model.unlock(ctrl);
    hang_check();
  endtask
  task automatic wait_done();
    i_cpu_bus_model.poll_go();
    hang_check();
  endtask
  task automatic t_eeprom();
    wr(PAYLOAD_OFF, 32'hA5);
    check(i_cpu_bus_model.resp, RESP_OKAY);
    launch(8'h00, EEPROM_BASE + 15'h34, 8'h2A);
    rd(STATUS_OFF, 32'h1);
    check(cpu_stall, 1'b0);
    wr(CONTROL_OFF, 32'h2A);
    rd(CONTROL_OFF, 32'h2B);
    wait_done();
    check(n_wr, 1);
    check(n_er, 0);
    check(op_loc, 15'h7034);
    check(mem_payload, 8'hA5);
    check(mem_space, 1'b1);
    check(n_stall, 0);
    rd(CONTROL_OFF, 32'h3A);
    check(completion_irq, 1'b1);
    check(n_lr, 1);
    wr(CONTROL_OFF, 32'h2A);
    rd(CONTROL_OFF, 32'h2A);
    check(completion_irq, 1'b0);
  endtask
  // code flash row first, then a user id row in the select space
  task automatic t_erase();
    launch(8'h00, 15'h1234, 8'h06);
    wait_done();
    check(n_er, 1);
    check(n_wr, 1);
    check(op_loc, 15'h1220);
    check(mem_space, 1'b0);
    check(n_stall >= ROW_ERASE_CYC - 1, 1'b1);
    check(n_stall <= ROW_ERASE_CYC + 1, 1'b1);
    rd(CONTROL_OFF, 32'h16);
    check(completion_irq, 1'b0);
    check(n_lr, 2);
    wr(CONTROL_OFF, 32'h00);
    launch(8'h00, 15'h0002, 8'h0E);
    wait_done();
    check(n_er, 2);
    check(op_loc, 15'h0000);
    check(mem_space, 1'b1);
    wr(CONTROL_OFF, 32'h00);
  endtask
  // a wrong order, an intruding write and a strobe-less key all fail
  task automatic t_bad_keys();
    launch(8'h00, 15'h7034, 8'h08);
    rd(STATUS_OFF, 32'h0);
    wr(CONTROL_OFF, 32'h0A);
    wr(KEY_OFF, {24'h0, KEY_FIRST});
    wr(PAYLOAD_OFF, 32'h5A);
    wr(KEY_OFF, {24'h0, KEY_SECOND});
    wr(CONTROL_OFF, 32'h0B);
    rd(STATUS_OFF, 32'h0);
    wr(KEY_OFF, {24'h0, KEY_SECOND});
    wr(KEY_OFF, {24'h0, KEY_FIRST});
    wr(CONTROL_OFF, 32'h0B);
    rd(STATUS_OFF, 32'h0);
    i_cpu_bus_model.xfer(1'b0, KEY_OFF, {24'h0, KEY_FIRST}, 4'h0);
    wr(KEY_OFF, {24'h0, KEY_SECOND});
    wr(CONTROL_OFF, 32'h0B);
    rd(STATUS_OFF, 32'h0);
    check(n_wr, 1);
  endtask
  task automatic t_blocked();
    logic [14:0] locs [4];
    logic [7:0]  ctls [4];
    logic [7:0]  prots [4];
    locs = '{15'h1234, 15'h7034, 15'h0006, 15'h7100};
    ctls = '{8'h06, 8'h0A, 8'h0A, 8'h0A};
    prots = '{8'h02, 8'h80, 8'h00, 8'h00};
    for (int i = 0; i < 4; i++) begin
      launch(prots[i], locs[i], ctls[i]);
      rd(STATUS_OFF, 32'h0);
      rd(CONTROL_OFF, {24'h0, ctls[i]});
    end
    check(n_wr, 1);
    check(n_er, 2);
    wr(PROTECT_OFF, 32'h0);
  endtask
  initial begin
    rst_b = 1'b0;
    repeat (20) @(posedge clk);
    check({27'h0, cpu_stall, completion_irq, mem_write, mem_row_erase,
           latch_reset}, 32'h0);
    rst_b <= 1'b1;
    rd(CONTROL_OFF, {24'h0, CONTROL_RESET});
    rd(PROTECT_OFF, {24'h0, PROTECT_RESET});
    rd(8'h1C, 32'h0);
    check(i_cpu_bus_model.resp, RESP_SLVERR);
    wr(8'h1C, 32'h0);
    check(i_cpu_bus_model.resp, RESP_SLVERR);
    t_eeprom();
    t_erase();
    t_bad_keys();
    t_blocked();
    final_report();
  end
endmodule
`default_nettype wire
